// ---- design/cew_pkg.sv ----
// package for the cache error and watch unit: register indices, field layouts, types
// assumes one processor clock and a plain coprocessor register port
//
// How it works
// - capture register is 32 bits, read-only, loaded when a cache error is taken
// - bad-parity read response, cached or uncached, raises a cache error
// - parity errors are only reported, data is never corrected
// - reference type 0 instruction 1 data; cache level 0 primary
// - data-field flag is 1 for a data field error, else 0
// - tag-field flag is 1 for a tag field error, else 0
// - external-source flag 1 for external request, 0 for internal
// - bus error flag set or cleared on every cache error
// - additional-data flag set when data error joins instruction error
// - physical address 21:3 goes into the secondary index field
// - virtual address 13:12 into primary index low bits, bit 2 zero
// - reserved capture bits read as zero
// - error return pc loads on reset, soft reset, nmi, cache error
// - no branch-delay indicator exists for the error return pc
// - error return pc holds faulting pc or preceding branch in delay slot
// - fetch address 31:2 equal to watch field with enable set raises watch
// - matches under exception or error level are held until both clear
// - instruction watch ranks just below instruction address error
// - fetch watch enable clears on reset
// - load address 31:3 matching data watch with load enable raises watch
// - store address matching data watch with store enable raises watch
// - data watch ranks below data address error; cache ops never match
package cew_pkg;
    // -------------------------------------------------------------------
    // register indices on the coprocessor port
    // -------------------------------------------------------------------
    localparam logic [4:0] CEW_REG_CACHE_ERR = 5'h1b;
    localparam logic [4:0] CEW_REG_ERR_PC = 5'h1e;
    localparam logic [4:0] CEW_REG_INSTRUCTION_WATCH_ADDRESS = 5'h12;
    localparam logic [4:0] CEW_REG_DATA_WATCH_ADDRESS = 5'h13;
    // -------------------------------------------------------------------
    // capture register field positions
    // -------------------------------------------------------------------
    localparam int CEW_CE_REF = 31;
    localparam int CEW_CE_LVL = 30;
    localparam int CEW_CE_DATA = 29;
    localparam int CEW_CE_TAG = 28;
    localparam int CEW_CE_EXT = 27;
    localparam int CEW_CE_BUS = 26;
    localparam int CEW_CE_ADD = 25;
    localparam int CEW_CE_SIDX_LO = 3;
    localparam int CEW_CE_PIDX_LO = 0;
    // -------------------------------------------------------------------
    // watch register field positions and reset values
    // -------------------------------------------------------------------
    localparam int CEW_IW_EN = 0;
    localparam int CEW_DW_STORE = 0;
    localparam int CEW_DW_LOAD = 1;
    localparam logic [31:0] CEW_WATCH_RST = 32'h0000_0000;
    localparam logic [31:0] CEW_ZERO = 32'h0000_0000;

    // one reported cache error from the cache and bus logic
    typedef struct packed {
        logic valid;
        logic is_data;
        logic data_field;
        logic tag_field;
        logic external;
        logic on_bus;
        logic extra_data;
        logic [31:0] paddr;
        logic [31:0] vaddr;
        logic [31:0] pc;
    } cew_err_type;

    // one memory reference offered for watching
    typedef struct packed {
        logic fetch;
        logic load;
        logic store;
        logic cache_op;
        logic addr_err;
        logic [31:0] vaddr;
    } cew_ref_type;

    typedef struct packed {
        logic [31:0] cache_err;
        logic [31:0] err_pc;
        logic [29:0] iw_addr;
        logic iw_en;
        logic [28:0] dw_addr;
        logic dw_load;
        logic dw_store;
        logic pend_i;
        logic pend_d;
        logic [31:0] rdata;
        logic watch_i;
        logic watch_d;
    } cew_state_type;
endpackage : cew_pkg

// ---- design/cew_unit.sv ----
// cache error capture, error return pc and two address watch comparators
// assumes all inputs are on i_clk; the core pulses one reference per cycle
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cew_unit (
    input wire logic i_clk, // processor clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic i_soft_rst, // soft reset pulse
    input wire logic i_nmi, // nmi taken pulse
    input wire logic [31:0] i_cur_pc, // pc of the excepting instruction
    input wire cew_pkg::cew_err_type i_err, // cache error report
    input wire cew_pkg::cew_ref_type i_ref, // reference to watch
    input wire logic i_exc_level, // exception_level_flag
    input wire logic i_err_level, // error_level_flag
    input wire logic [4:0] i_addr, // register index
    input wire logic [31:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [31:0] o_rdata, // read data, cycle after strobe
    output logic o_cache_err, // cache error exception request
    output logic o_watch_i, // instruction watch exception
    output logic o_watch_d, // data watch exception
    output logic [31:0] o_err_pc // error_return_pc
);
    cew_pkg::cew_state_type s_q;
    cew_pkg::cew_state_type s_d;
    logic i_hit;
    logic d_hit;
    logic free;

    // -------------------------------------------------------------------
    // watch compare
    // -------------------------------------------------------------------
    always_comb begin
        free = !i_exc_level && !i_err_level;
        i_hit = i_ref.fetch && s_q.iw_en && (i_ref.vaddr[31:2] == s_q.iw_addr);
        d_hit = !i_ref.cache_op && (i_ref.vaddr[31:3] == s_q.dw_addr)
            && ((i_ref.load && s_q.dw_load) || (i_ref.store && s_q.dw_store));
    end

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = cew_pkg::CEW_ZERO;
        s_d.watch_i = 1'b0;
        s_d.watch_d = 1'b0;
        // address error outranks the watch, so a hit on an errant fetch is dropped
        if (i_hit && !i_ref.addr_err) begin
            s_d.pend_i = 1'b1;
        end
        if (d_hit && !i_ref.addr_err) begin
            s_d.pend_d = 1'b1;
        end
        if (free && s_d.pend_i) begin
            s_d.watch_i = 1'b1;
            s_d.pend_i = 1'b0;
        end
        if (free && s_d.pend_d) begin
            s_d.watch_d = 1'b1;
            s_d.pend_d = 1'b0;
        end
        if (i_wr) begin
            unique case (i_addr)
                cew_pkg::CEW_REG_ERR_PC: s_d.err_pc = i_wdata;
                cew_pkg::CEW_REG_INSTRUCTION_WATCH_ADDRESS: begin
                    s_d.iw_addr = i_wdata[31:2];
                    s_d.iw_en = i_wdata[cew_pkg::CEW_IW_EN];
                end
                cew_pkg::CEW_REG_DATA_WATCH_ADDRESS: begin
                    s_d.dw_addr = i_wdata[31:3];
                    s_d.dw_load = i_wdata[cew_pkg::CEW_DW_LOAD];
                    s_d.dw_store = i_wdata[cew_pkg::CEW_DW_STORE];
                end
                default: ; // capture register ignores writes
            endcase
        end
        if (i_err.valid) begin
            // only reporting: the erroneous data is left as it is
            s_d.cache_err = cew_pkg::CEW_ZERO;
            s_d.cache_err[cew_pkg::CEW_CE_REF] = i_err.is_data;
            s_d.cache_err[cew_pkg::CEW_CE_LVL] = 1'b0;
            s_d.cache_err[cew_pkg::CEW_CE_DATA] = i_err.data_field;
            s_d.cache_err[cew_pkg::CEW_CE_TAG] = i_err.tag_field;
            s_d.cache_err[cew_pkg::CEW_CE_EXT] = i_err.external;
            s_d.cache_err[cew_pkg::CEW_CE_BUS] = i_err.on_bus;
            s_d.cache_err[cew_pkg::CEW_CE_ADD] = i_err.extra_data && !i_err.is_data;
            s_d.cache_err[21:3] = i_err.paddr[21:3];
            s_d.cache_err[2:0] = {1'b0, i_err.vaddr[13:12]};
        end
        // hardware load beats a same-cycle software write; no delay-slot bit kept
        if (i_err.valid) begin
            s_d.err_pc = i_err.pc;
        end else if (i_soft_rst || i_nmi) begin
            s_d.err_pc = i_cur_pc;
        end
        if (i_rd) begin
            unique case (i_addr)
                cew_pkg::CEW_REG_CACHE_ERR: s_d.rdata = s_q.cache_err;
                cew_pkg::CEW_REG_ERR_PC: s_d.rdata = s_q.err_pc;
                cew_pkg::CEW_REG_INSTRUCTION_WATCH_ADDRESS: s_d.rdata = {s_q.iw_addr, 1'b0, s_q.iw_en};
                cew_pkg::CEW_REG_DATA_WATCH_ADDRESS:
                    s_d.rdata = {s_q.dw_addr, 1'b0, s_q.dw_load, s_q.dw_store};
                default: s_d.rdata = cew_pkg::CEW_ZERO;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_q <= '0;
            s_q.err_pc <= i_cur_pc;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_cache_err = i_err.valid;
    assign o_watch_i = s_q.watch_i;
    assign o_watch_d = s_q.watch_d;
    assign o_err_pc = s_q.err_pc;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    defer_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_exc_level || i_err_level) |-> !s_d.watch_i && !s_d.watch_d)
        else $error("watch taken while level flag set");
    fetch_hit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_hit && !i_ref.addr_err && free) |=> o_watch_i)
        else $error("fetch watch hit not taken");
    data_hit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (d_hit && !i_ref.addr_err && free) |=> o_watch_d)
        else $error("data watch hit not taken");
    cache_op_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_ref.cache_op && !s_q.pend_d) |=> !o_watch_d)
        else $error("cache op raised data watch");
    err_pc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_err.valid |=> o_err_pc == $past(i_err.pc))
        else $error("error pc not loaded");
    sidx_cap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_err.valid |=> s_q.cache_err[21:3] == $past(i_err.paddr[21:3]))
        else $error("secondary index wrong");
    pidx_cap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_err.valid |=> s_q.cache_err[2:0] == {1'b0, $past(i_err.vaddr[13:12])})
        else $error("primary index wrong");
    resv_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_q.cache_err[24:22] == 3'h0 && !s_q.cache_err[30])
        else $error("reserved capture bits set");
    bus_flag_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_err.valid |=> s_q.cache_err[26] == $past(i_err.on_bus))
        else $error("bus flag not updated");
    ro_capture_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_err.valid |=> $stable(s_q.cache_err))
        else $error("capture register changed without error");
    reset_en_a: assert property (@(posedge i_clk)
        i_sys_rst |=> !s_q.iw_en && !s_q.dw_load && !s_q.dw_store)
        else $error("watch enables not cleared by reset");
endmodule : cew_unit
`default_nettype wire

// ---- tb/cew_unit_tb.sv ----
// bench for the cache error and watch unit: register, error and watch sequences
// assumes read data one cycle after the strobe and registered watch pulses
`timescale 1ns/1ps
`default_nettype none
module cew_unit_tb;
    // -----------------------------------------------------------------
    // signals
    // -----------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_soft_rst = 1'b0;
    logic i_nmi = 1'b0;
    logic [31:0] i_cur_pc = 32'h1fc0_0000;
    cew_pkg::cew_err_type i_err = '0;
    cew_pkg::cew_ref_type i_ref = '0;
    logic [1:0] lvl = 2'h0;
    logic [4:0] i_addr = 5'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata, o_err_pc, cap_exp;
    logic o_cache_err, o_watch_i, o_watch_d;
    int n_fail = 0;
    int check_count = 0;
    cew_unit uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_soft_rst(i_soft_rst),
        .i_nmi(i_nmi), .i_cur_pc(i_cur_pc), .i_err(i_err), .i_ref(i_ref),
        .i_exc_level(lvl[1]), .i_err_level(lvl[0]), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cache_err(o_cache_err),
        .o_watch_i(o_watch_i), .o_watch_d(o_watch_d), .o_err_pc(o_err_pc));
    always #12.5 i_clk = ~i_clk;
    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input string what, input logic [4:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(what, exp, o_rdata);
    endtask : rd
    // q is {fetch, load, store, cache_op, addr_err}; e is {watch_i, watch_d}
    task automatic probe(input logic [4:0] q, input logic [31:0] va, input logic [1:0] e);
        @(posedge i_clk);
        i_ref <= {q, va};
        @(posedge i_clk);
        i_ref <= '0;
        #1 chk("watch", {30'h0, e}, {30'h0, o_watch_i, o_watch_d});
    endtask : probe
    // deferred pulses are collected over the three cycles after the levels drop
    task automatic late(input logic [1:0] e);
        logic [1:0] seen;
        seen = 2'h0;
        repeat (3) begin
            @(posedge i_clk);
            #1 seen = seen | {o_watch_i, o_watch_d};
        end
        chk("late watch", {30'h0, e}, {30'h0, seen});
    endtask : late
    // f is {is_data, data_field, tag_field, external, on_bus, extra_data}
    task automatic err(input logic [5:0] f, input logic [31:0] pa, va, pc, input logic sw);
        @(posedge i_clk);
        i_err <= {1'b1, f, pa, va, pc};
        i_wr <= sw;
        i_addr <= cew_pkg::CEW_REG_ERR_PC;
        i_wdata <= 32'hdead_0000;
        cap_exp = {f[5], 1'b0, f[4:1], f[0] & ~f[5], 3'h0, pa[21:3], 1'b0, va[13:12]};
        #1 chk("cache_err", 32'h1, {31'h0, o_cache_err});
        @(posedge i_clk);
        i_err <= '0;
        i_wr <= 1'b0;
        rd("capture", cew_pkg::CEW_REG_CACHE_ERR, cap_exp);
        rd("err_pc", cew_pkg::CEW_REG_ERR_PC, pc);
    endtask : err
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    // -----------------------------------------------------------------
    // tests
    // -----------------------------------------------------------------
    initial begin
        #(25 * 3000);
        n_fail++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd("instruction_watch_address", cew_pkg::CEW_REG_INSTRUCTION_WATCH_ADDRESS, cew_pkg::CEW_WATCH_RST);
        rd("data_watch_address", cew_pkg::CEW_REG_DATA_WATCH_ADDRESS, cew_pkg::CEW_WATCH_RST);
        rd("capture", cew_pkg::CEW_REG_CACHE_ERR, cew_pkg::CEW_ZERO);
        rd("unmapped", 5'h00, cew_pkg::CEW_ZERO);
        rd("err_pc", cew_pkg::CEW_REG_ERR_PC, 32'h1fc0_0000);
        probe(5'h10, 32'h0000_0000, 2'h0);
        $display("test reset done");
        wr(cew_pkg::CEW_REG_INSTRUCTION_WATCH_ADDRESS, 32'h0040_1007);
        rd("instruction_watch_address", cew_pkg::CEW_REG_INSTRUCTION_WATCH_ADDRESS, 32'h0040_1005);
        probe(5'h10, 32'h0040_1004, 2'h2);
        probe(5'h10, 32'h0040_1007, 2'h2);
        probe(5'h10, 32'h0040_1000, 2'h0);
        probe(5'h11, 32'h0040_1004, 2'h0);
        probe(5'h0c, 32'h0040_1004, 2'h0);
        for (int k = 1; k < 4; k++) begin
            @(posedge i_clk);
            lvl <= k[1:0];
            probe(5'h10, 32'h0040_1004, 2'h0);
            @(posedge i_clk);
            lvl <= 2'h0;
            late(2'h2);
        end
        wr(cew_pkg::CEW_REG_INSTRUCTION_WATCH_ADDRESS, 32'h0040_1004);
        probe(5'h10, 32'h0040_1004, 2'h0);
        $display("test instruction watch done");
        wr(cew_pkg::CEW_REG_DATA_WATCH_ADDRESS, 32'h1234_567f);
        rd("data_watch_address", cew_pkg::CEW_REG_DATA_WATCH_ADDRESS, 32'h1234_567b);
        probe(5'h08, 32'h1234_567c, 2'h1);
        probe(5'h04, 32'h1234_5678, 2'h1);
        probe(5'h0a, 32'h1234_5678, 2'h0);
        probe(5'h05, 32'h1234_5678, 2'h0);
        probe(5'h08, 32'h1234_5680, 2'h0);
        probe(5'h10, 32'h1234_5678, 2'h0);
        wr(cew_pkg::CEW_REG_DATA_WATCH_ADDRESS, 32'h1234_5679);
        probe(5'h08, 32'h1234_5678, 2'h0);
        @(posedge i_clk);
        lvl <= 2'h2;
        probe(5'h04, 32'h1234_5678, 2'h0);
        @(posedge i_clk);
        lvl <= 2'h0;
        late(2'h1);
        $display("test data watch done");
        err(6'h1f, 32'hfedc_ba98, 32'h0000_3000, 32'h8000_0104, 1'b0);
        wr(cew_pkg::CEW_REG_CACHE_ERR, 32'hffff_ffff);
        rd("capture ro", cew_pkg::CEW_REG_CACHE_ERR, cap_exp);
        err(6'h29, 32'h0012_3458, 32'h0000_2000, 32'h8000_0200, 1'b1);
        wr(cew_pkg::CEW_REG_ERR_PC, 32'h8000_0300);
        rd("err_pc rw", cew_pkg::CEW_REG_ERR_PC, 32'h8000_0300);
        $display("test cache error done");
        for (int k = 1; k < 3; k++) begin
            @(posedge i_clk);
            i_cur_pc <= 32'h8000_0400 + k;
            {i_soft_rst, i_nmi} <= k[1:0];
            @(posedge i_clk);
            {i_soft_rst, i_nmi} <= 2'h0;
            #1 chk("err_pc event", 32'h8000_0400 + k, o_err_pc);
        end
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd("instruction_watch_address again", cew_pkg::CEW_REG_INSTRUCTION_WATCH_ADDRESS, cew_pkg::CEW_WATCH_RST);
        rd("err_pc again", cew_pkg::CEW_REG_ERR_PC, 32'h8000_0402);
        $display("test events done");
        report_and_stop();
    end
endmodule : cew_unit_tb
`default_nettype wire
